/* rtl/rcotr_ovr.sv */
`timescale 1ns/1ps
`default_nettype none

module rcotr_ovr (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [15:0] i_gen,
    input wire rcotr_pkg::rcotr_masks_t i_masks,
    output logic [15:0] o_used,
    output logic o_upmix_pd
);
    import rcotr_pkg::*;

    logic [15:0] next_used;

    // and then or, per signal
    assign next_used = (i_gen & i_masks.and_mask) | i_masks.or_mask; // [R9]

    // one flop stage so the pins never glitch on a mask write
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_used <= OR_MASK_RESET;
            o_upmix_pd <= 1'b0;
        end else begin
            o_used <= next_used; // [R17]
            o_upmix_pd <= next_used[BIT_AMP_NEG_PD] &
                next_used[BIT_AMP_POS_PD]; // [R15]
        end
    end

endmodule

`default_nettype wire

/* rtl/rcotr_pkg.sv */
package rcotr_pkg;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0] ADDR_ID_LOWER = 8'h1E;
    localparam logic [7:0] ADDR_ID_UPPER = 8'h1F;
    localparam logic [7:0] ADDR_TIME_CONST = 8'h20;
    localparam logic [7:0] ADDR_AND_MASK = 8'h21;
    localparam logic [7:0] ADDR_OR_MASK = 8'h22;
    localparam logic [7:0] ADDR_CTRL_STATUS = 8'h30;
    localparam logic [7:0] ADDR_SEQ_STATUS = 8'h31;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [15:0] TIME_CONST_RESET = 16'h7A94;
    localparam logic [15:0] AND_MASK_RESET = 16'hFFFF;
    localparam logic [15:0] OR_MASK_RESET = 16'h0000;

    // ****************************************************************
    // identity field positions
    // ****************************************************************
    localparam int ID_HIGH_LSB = 12;
    localparam int ID_LOW_MSB = 11;

    // ****************************************************************
    // control word bit positions
    // ****************************************************************
    localparam int BIT_PEAKDET_RESET_N = 15;
    localparam int BIT_GLOBAL_GLOBAL_BIAS_POWERDOWN = 14;
    localparam int BIT_OUTPUT_SWITCH = 13;
    localparam int BIT_PATH_SELECT = 12;
    localparam int BIT_AMP_NEG_PD = 10;
    localparam int BIT_AMP_POS_PD = 9;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int MICROSECOND_NS = 1000;
    localparam int CYCLES_PER_US = MICROSECOND_NS / CLK_PERIOD_NS;
    localparam logic [7:0] RX_STEP_US = 8'h05;
    localparam int HALF_SYMBOL_US = 8;
    localparam int CAL_HALF_SYMBOLS = 13;
    localparam logic [7:0] CAL_US = 8'(HALF_SYMBOL_US * CAL_HALF_SYMBOLS);

    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic [2:0] rx_chain_to_demod_delay;
        logic [2:0] switch_lead_time;
        logic [3:0] amp_powerup_lead_time;
        logic [2:0] tx_end_switch_off_delay;
        logic [2:0] tx_end_amp_off_delay;
    } rcotr_tc_t;

    typedef struct packed {
        logic [15:0] and_mask;
        logic [15:0] or_mask;
    } rcotr_masks_t;

    typedef enum logic [2:0] {
        st_idle,
        st_cal,
        st_rxchain,
        st_rx,
        st_txlead,
        st_tx,
        st_tail
    } rcotr_state_t;

endpackage

/* rtl/rcotr_tick.sv */
`timescale 1ns/1ps
`default_nettype none

module rcotr_tick (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_restart,
    output logic o_tick
);
    import rcotr_pkg::*;

    localparam logic [6:0] LAST = 7'(CYCLES_PER_US - 1);

    logic [6:0] cnt;

    // restart aligns the first pulse to a whole microsecond
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || i_restart) begin
            cnt <= 7'h00;
        end else if (cnt == LAST) begin
            cnt <= 7'h00;
        end else begin
            cnt <= cnt + 7'h01;
        end
    end

    assign o_tick = (cnt == LAST) && !i_restart;

endmodule

`default_nettype wire

/* rtl/rcotr_top.sv */
// How it works
// [R1] upper identity top nibble: read-only revision
// [R2] upper identity low bits: upper part number
// [R3] demod enable waits count times 5 us
// [R4] rx chain starts after 6.5 symbol calibration
// [R5] switch raised early by programmed microseconds
// [R6] amplifier powered early by programmed microseconds
// [R7] switch off programmed microseconds after packet
// [R8] amplifier and modulator off after programmed delay
// [R9] delivered signal is generated and-mask or-mask
// [R10] software forces front end low via masks
// [R11] software forces front end high via masks
// [R12] bit 15 masks peak detector reset
// [R13] bit 12 selects oscillator or amplifier buffers
// [R14] bit 13 gives amplifier external bias
// [R15] both amplifier powerdowns also power down mixers
// [R16] masks cover bias and twelve powerdown controls
// [R17] mask writes reach outputs next cycle
// [R18] lower identity: part number bits, maker code
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module rcotr_top #(
    parameter logic [3:0] REVISION = 4'h1, // arbitrary value
    parameter logic [15:0] PART_NUMBER = 16'h0ABC, // arbitrary value
    parameter logic [11:0] MAKER_CODE = 12'h5A5 // arbitrary value
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    input wire logic [15:0] i_ctrl_gen,
    input wire logic i_rx_req,
    input wire logic i_tx_req,
    input wire logic i_last_chip,
    output logic [15:0] o_ctrl,
    output logic o_upmix_pd,
    output logic o_rx_chain_en,
    output logic o_demod_en,
    output logic o_tx_en,
    output logic o_mod_en
);
    import rcotr_pkg::*;

    // ****************************************************************
    // register file
    // ****************************************************************
    rcotr_tc_t tc;
    rcotr_masks_t masks;
    rcotr_masks_t next_masks;
    logic [15:0] rd_value;
    logic sw_on;
    logic amp_on;

    // write decode; identity words have no storage so writes vanish
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            tc <= rcotr_tc_t'(TIME_CONST_RESET);
        end else if (i_wr && i_addr == ADDR_TIME_CONST) begin
            tc <= rcotr_tc_t'(i_wdata);
        end
    end

    // masks take the written value in the same edge as the write
    always_comb begin
        next_masks = masks;
        if (i_wr && i_addr == ADDR_AND_MASK) begin
            next_masks.and_mask = i_wdata; // [R10]
        end
        if (i_wr && i_addr == ADDR_OR_MASK) begin
            next_masks.or_mask = i_wdata; // [R11]
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            masks.and_mask <= AND_MASK_RESET;
            masks.or_mask <= OR_MASK_RESET;
        end else begin
            masks <= next_masks;
        end
    end

    // read mux; unmapped addresses read as zero
    always_comb begin
        rd_value = 16'h0000;
        unique case (i_addr)
            ADDR_ID_LOWER: begin
                rd_value = {PART_NUMBER[3:0], MAKER_CODE}; // [R18]
            end
            ADDR_ID_UPPER: begin
                rd_value[15:ID_HIGH_LSB] = REVISION; // [R1]
                rd_value[ID_LOW_MSB:0] = PART_NUMBER[15:4]; // [R2]
            end
            ADDR_TIME_CONST: begin
                rd_value = 16'(tc);
            end
            ADDR_AND_MASK: begin
                rd_value = masks.and_mask;
            end
            ADDR_OR_MASK: begin
                rd_value = masks.or_mask;
            end
            ADDR_CTRL_STATUS: begin
                rd_value = o_ctrl;
            end
            ADDR_SEQ_STATUS: begin
                rd_value = {10'h000, o_rx_chain_en, o_demod_en,
                    sw_on, amp_on, o_tx_en, o_mod_en};
            end
            default: begin
                rd_value = 16'h0000;
            end
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            o_rdata <= rd_value;
        end else begin
            o_rdata <= 16'h0000;
        end
    end

    // ****************************************************************
    // microsecond base
    // ****************************************************************
    rcotr_state_t state;
    rcotr_state_t next_state;
    logic state_change;
    logic us_tick;
    logic [7:0] us_cnt;
    logic [7:0] elapsed;

    assign state_change = (next_state != state);

    // the divider restarts on every state entry, so a wait of n
    // microseconds is exactly n times the divider period
    rcotr_tick u_tick (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_restart(state_change),
        .o_tick(us_tick)
    );

    // elapsed microseconds in the current state, saturating
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || state_change) begin
            us_cnt <= 8'h00;
        end else if (us_tick && us_cnt != 8'hFF) begin
            us_cnt <= us_cnt + 8'h01;
        end
    end

    // time as seen in the state about to be held
    assign elapsed = state_change ? 8'h00 : us_cnt;

    // ****************************************************************
    // sequencing thresholds
    // ****************************************************************
    logic [7:0] rx_wait_us;
    logic [3:0] lead_us;
    logic [3:0] sw_start_us;
    logic [3:0] amp_start_us;
    logic [2:0] tail_us;
    logic [3:0] sw_lead;

    assign sw_lead = {1'b0, tc.switch_lead_time};

    // demod wait in 5 us steps
    assign rx_wait_us = 8'(tc.rx_chain_to_demod_delay) * RX_STEP_US; // [R3]

    // the longer lead sets when the transmitter starts
    assign lead_us = (sw_lead > tc.amp_powerup_lead_time) ?
        sw_lead : tc.amp_powerup_lead_time;
    assign sw_start_us = lead_us - sw_lead; // [R5]
    assign amp_start_us = lead_us - tc.amp_powerup_lead_time; // [R6]

    // the tail lasts until both shut-offs have happened
    assign tail_us = (tc.tx_end_switch_off_delay >
        tc.tx_end_amp_off_delay) ? tc.tx_end_switch_off_delay :
        tc.tx_end_amp_off_delay;

    // ****************************************************************
    // radio sequencer
    // ****************************************************************
    always_comb begin
        next_state = state;
        unique case (state)
            st_idle: begin
                // transmit wins when both arrive together
                if (i_tx_req) begin
                    next_state = st_txlead;
                end else if (i_rx_req) begin
                    next_state = st_cal;
                end
            end
            st_cal: begin
                if (!i_rx_req) begin
                    next_state = st_idle;
                end else if (us_cnt >= CAL_US) begin
                    next_state = st_rxchain; // [R4]
                end
            end
            st_rxchain: begin
                if (!i_rx_req) begin
                    next_state = st_idle;
                end else if (us_cnt >= rx_wait_us) begin
                    next_state = st_rx; // [R3]
                end
            end
            st_rx: begin
                if (i_tx_req) begin
                    next_state = st_txlead;
                end else if (!i_rx_req) begin
                    next_state = st_idle;
                end
            end
            st_txlead: begin
                if (us_cnt >= {4'h0, lead_us}) begin
                    next_state = st_tx;
                end
            end
            st_tx: begin
                if (i_last_chip) begin
                    next_state = st_tail;
                end
            end
            st_tail: begin
                if (us_cnt >= {5'h00, tail_us}) begin
                    next_state = st_idle;
                end
            end
            default: begin
                next_state = st_idle;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state <= st_idle;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // receive side enables
    // ****************************************************************
    // chain enable only after calibration, demod after the wait
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rx_chain_en <= 1'b0;
            o_demod_en <= 1'b0;
        end else begin
            o_rx_chain_en <= (next_state == st_rxchain) ||
                (next_state == st_rx); // [R4]
            o_demod_en <= (next_state == st_rx); // [R3]
        end
    end

    // ****************************************************************
    // transmit side enables
    // ****************************************************************
    // switch: raised early in the lead, dropped after the tail delay
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sw_on <= 1'b0;
        end else begin
            unique case (next_state)
                st_txlead: begin
                    sw_on <= (elapsed >= {4'h0, sw_start_us}); // [R5]
                end
                st_tx: begin
                    sw_on <= 1'b1;
                end
                st_tail: begin
                    sw_on <= (elapsed <
                        {5'h00, tc.tx_end_switch_off_delay}); // [R7]
                end
                default: begin
                    sw_on <= 1'b0;
                end
            endcase
        end
    end

    // amplifier: powered early in the lead, down after the tail delay
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            amp_on <= 1'b0;
        end else begin
            unique case (next_state)
                st_txlead: begin
                    amp_on <= (elapsed >= {4'h0, amp_start_us}); // [R6]
                end
                st_tx: begin
                    amp_on <= 1'b1;
                end
                st_tail: begin
                    amp_on <= (elapsed <
                        {5'h00, tc.tx_end_amp_off_delay}); // [R8]
                end
                default: begin
                    amp_on <= 1'b0;
                end
            endcase
        end
    end

    // transmit enable ends with the packet, modulator with the amp
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_tx_en <= 1'b0;
            o_mod_en <= 1'b0;
        end else begin
            o_tx_en <= (next_state == st_tx);
            o_mod_en <= (next_state == st_tx) ||
                ((next_state == st_tail) &&
                (elapsed < {5'h00, tc.tx_end_amp_off_delay})); // [R8]
        end
    end

    // ****************************************************************
    // override stage
    // ****************************************************************
    logic [15:0] gen_ctrl;

    // sequencer owns path select and both amplifier powerdowns; the
    // rest, bias, peak reset and the powerdowns, pass from the core
    always_comb begin
        gen_ctrl = i_ctrl_gen; // [R16]
        gen_ctrl[BIT_PATH_SELECT] = sw_on; // [R13]
        gen_ctrl[BIT_OUTPUT_SWITCH] = i_ctrl_gen[BIT_OUTPUT_SWITCH]; // [R14]
        gen_ctrl[BIT_PEAKDET_RESET_N] =
            i_ctrl_gen[BIT_PEAKDET_RESET_N]; // [R12]
        gen_ctrl[BIT_AMP_NEG_PD] = !amp_on;
        gen_ctrl[BIT_AMP_POS_PD] = !amp_on;
    end

    // masks go in as next values so a write shows one cycle later
    rcotr_ovr u_ovr (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_gen(gen_ctrl),
        .i_masks(next_masks), // [R17]
        .o_used(o_ctrl),
        .o_upmix_pd(o_upmix_pd)
    );

endmodule

`default_nettype wire

/* testbench/rcotr_afe_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ********
// front end seen from the delivered controls
// ********
module rcotr_afe_model (
    input wire logic [15:0] i_ctrl,
    output logic o_mix_off,
    output logic o_front_end_on
);
    import rcotr_pkg::*;
    // mixers follow both amplifier powerdowns, front end follows bit 0; other bits only consumed
    assign o_mix_off = i_ctrl[BIT_AMP_NEG_PD] & i_ctrl[BIT_AMP_POS_PD];
    assign o_front_end_on = !i_ctrl[0];
endmodule
`default_nettype wire

/* testbench/rcotr_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ********
// checker on the top ports
// ********
module rcotr_monitor #(
    parameter logic [3:0] REVISION = 4'h1,
    parameter logic [15:0] PART_NUMBER = 16'h0ABC,
    parameter logic [11:0] MAKER_CODE = 12'h5A5
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic [15:0] i_ctrl_gen,
    input wire logic i_rx_req,
    input wire logic i_tx_req,
    input wire logic i_last_chip,
    input wire logic [15:0] o_ctrl,
    input wire logic o_upmix_pd,
    input wire logic o_rx_chain_en,
    input wire logic o_demod_en,
    input wire logic o_tx_en,
    input wire logic o_mod_en
);
    import rcotr_pkg::*;
    // bits 12, 10 and 9 are replaced by the sequencer
    localparam logic [15:0] KEEP = 16'hE9FF;
    logic [15:0] tc_q;
    logic [15:0] and_q;
    logic [15:0] or_q;
    // shadow copies of the writable registers
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            tc_q <= TIME_CONST_RESET;
            and_q <= AND_MASK_RESET;
            or_q <= OR_MASK_RESET;
        end else if (i_wr) begin
            if (i_addr == ADDR_TIME_CONST) tc_q <= i_wdata;
            if (i_addr == ADDR_AND_MASK) and_q <= i_wdata;
            if (i_addr == ADDR_OR_MASK) or_q <= i_wdata;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    ctrl_mask_a: assert property ($past(i_rst_n) |->
        (o_ctrl & KEEP) == ((($past(i_ctrl_gen) & and_q) | or_q) & KEEP))
        else $error("masked control word wrong");
    upmix_pd_a: assert property ($past(i_rst_n) |->
        o_upmix_pd == (o_ctrl[10] & o_ctrl[9]))
        else $error("mixer powerdown wrong");
    id_upper_a: assert property (i_rd && i_addr == ADDR_ID_UPPER
        |=> o_rdata == {REVISION, PART_NUMBER[15:4]})
        else $error("upper identity wrong");
    id_lower_a: assert property (i_rd && i_addr == ADDR_ID_LOWER
        |=> o_rdata == {PART_NUMBER[3:0], MAKER_CODE})
        else $error("lower identity wrong");
    tc_read_a: assert property (i_rd && i_addr == ADDR_TIME_CONST
        |=> o_rdata == $past(tc_q)) else $error("time constants wrong");
    and_read_a: assert property (i_rd && i_addr == ADDR_AND_MASK
        |=> o_rdata == $past(and_q)) else $error("and mask wrong");
    rdata_idle_a: assert property (!i_rd |=> o_rdata == 16'h0000)
        else $error("read data not cleared");
    tx_stop_a: assert property (i_last_chip && o_tx_en |=> !o_tx_en)
        else $error("transmit enable kept");
    mod_off_a: assert property (i_last_chip && o_tx_en &&
        tc_q[2:0] == 3'h2 |=> o_mod_en[*8] ##[230:260] !o_mod_en)
        else $error("modulator off time wrong");
    sw_off_a: assert property (i_last_chip && o_tx_en &&
        tc_q[5:3] == 3'h1 && and_q == 16'hFFFF && or_q == 16'h0000
        |=> o_ctrl[12] ##[110:135] !o_ctrl[12])
        else $error("switch off time wrong");
endmodule
bind rcotr_top rcotr_monitor #(.REVISION(REVISION),
    .PART_NUMBER(PART_NUMBER), .MAKER_CODE(MAKER_CODE)) rcotr_monitor_i (.*);
`default_nettype wire

/* testbench/rcotr_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ********
// bench
// ********
module rcotr_top_tb;
    import rcotr_pkg::*;
    localparam logic [3:0] REV = 4'h3; // arbitrary value
    localparam logic [15:0] PN = 16'h1234; // arbitrary value
    localparam logic [11:0] MC = 12'h0F1; // arbitrary value
    logic i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, rd_d = 0;
    logic i_rx_req = 0, i_tx_req = 0, i_last_chip = 0;
    logic [7:0] i_addr = 0;
    logic [15:0] i_wdata = 0, i_ctrl_gen = 0, o_rdata, o_ctrl, g, a, o, e;
    logic o_upmix_pd, o_rx_chain_en, o_demod_en, o_tx_en, o_mod_en;
    logic mix_off, fe_on;
    logic [15:0] expq[$];
    int mismatches = 0, compares = 0, cyc = 0, t0 = 0;
    always #4 i_clk = ~i_clk;
    always @(posedge i_clk) cyc <= cyc + 1;
    rcotr_top #(.REVISION(REV), .PART_NUMBER(PN), .MAKER_CODE(MC))
    rcotr_top_i (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_ctrl_gen(i_ctrl_gen), .i_rx_req(i_rx_req), .i_tx_req(i_tx_req),
        .i_last_chip(i_last_chip), .o_ctrl(o_ctrl), .o_upmix_pd(o_upmix_pd),
        .o_rx_chain_en(o_rx_chain_en), .o_demod_en(o_demod_en),
        .o_tx_en(o_tx_en), .o_mod_en(o_mod_en)
    );
    rcotr_afe_model rcotr_afe_model_i (
        .i_ctrl(o_ctrl), .o_mix_off(mix_off), .o_front_end_on(fe_on)
    );
    task end_of_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input string n, input logic [15:0] ex, input logic [15:0] got);
        compares++;
        if (got !== ex) begin
            mismatches++;
            $display("mismatch %s exp %h got %h", n, ex, got);
        end
    endtask
    // read data stand only in the cycle after the strobe
    always @(posedge i_clk) begin
        rd_d <= i_rd;
        if (rd_d) chk("rdata", expq.pop_front(), o_rdata);
    end
    task wr(input logic [7:0] ad, input logic [15:0] d);
        @(posedge i_clk);
        i_addr <= ad;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] ad, input logic [15:0] ex);
        @(posedge i_clk);
        i_addr <= ad;
        i_rd <= 1'b1;
        expq.push_back(ex);
        @(posedge i_clk);
        i_rd <= 1'b0;
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: pick = !o_ctrl[10];
            1: pick = o_ctrl[12];
            2: pick = o_tx_en;
            3: pick = !o_ctrl[12];
            4: pick = o_ctrl[10] && !o_mod_en;
            5: pick = o_rx_chain_en;
            default: pick = o_demod_en;
        endcase
    endfunction
    // bounded wait for an event, then its delay from t0 within 4 cycles
    task upto(input int s, input int ex);
        int n;
        n = 0;
        while (!pick(s) && n < 20000) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        if (n >= 20000) begin
            $display("mismatch wait%0d timed out", s);
            mismatches++;
            end_of_test;
        end
        compares++;
        if (cyc - t0 < ex - 4 || cyc - t0 > ex + 4) begin
            mismatches++;
            $display("mismatch delay%0d exp %0d got %0d", s, ex, cyc - t0);
        end
    endtask
    initial begin
        g = $urandom(32'hAE06);
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(ADDR_TIME_CONST, {3'h3, 3'h6, 4'hA, 3'h2, 3'h4});
        rd(ADDR_AND_MASK, 16'hFFFF);
        rd(ADDR_OR_MASK, 16'h0000);
        wr(ADDR_ID_UPPER, 16'hFFFF);
        rd(ADDR_ID_UPPER, {REV, PN[15:4]});
        rd(ADDR_ID_LOWER, {PN[3:0], MC});
        rd(8'h40, 16'h0000);
        // idle sequencer: nothing enabled in the status word
        rd(ADDR_SEQ_STATUS, 16'h0000);
        // idle sequencer: switch off, both amplifier halves down
        repeat (8) begin
            g = $urandom;
            a = $urandom;
            o = $urandom;
            i_ctrl_gen <= g;
            wr(ADDR_AND_MASK, a);
            wr(ADDR_OR_MASK, o);
            rd(ADDR_AND_MASK, a);
            rd(ADDR_OR_MASK, o);
            e = (((g & 16'hE9FF) | 16'h0600) & a) | o;
            rd(ADDR_CTRL_STATUS, e);
            chk("ctrl", e, o_ctrl);
            chk("upmix", {15'h0000, e[10] & e[9]}, {15'h0000, o_upmix_pd});
            chk("mix", {15'h0000, o_upmix_pd}, {15'h0000, mix_off});
        end
        i_ctrl_gen <= 16'hFFFF;
        wr(ADDR_OR_MASK, 16'h0000);
        wr(ADDR_AND_MASK, 16'hFFFE);
        #1;
        chk("fe_low", 16'h0001, {15'h0000, fe_on});
        i_ctrl_gen <= 16'h0000;
        wr(ADDR_AND_MASK, 16'hFFFF);
        wr(ADDR_OR_MASK, 16'h0001);
        #1;
        chk("fe_high", 16'h0001, {15'h0000, o_ctrl[0]});
        wr(ADDR_OR_MASK, 16'h0000);
        // short leads: switch 2 us, amp 3 us, tails 1 and 2 us
        wr(ADDR_TIME_CONST, {3'h3, 3'h2, 4'h3, 3'h1, 3'h2});
        @(posedge i_clk);
        i_tx_req <= 1'b1;
        t0 = cyc;
        @(posedge i_clk);
        i_tx_req <= 1'b0;
        upto(0, 0);
        upto(1, 125);
        upto(2, 375);
        repeat (20) @(posedge i_clk);
        i_last_chip <= 1'b1;
        t0 = cyc;
        @(posedge i_clk);
        i_last_chip <= 1'b0;
        upto(3, 125);
        upto(4, 250);
        @(posedge i_clk);
        i_rx_req <= 1'b1;
        t0 = cyc;
        upto(5, 13000);
        t0 = cyc;
        upto(6, 1875);
        i_rx_req <= 1'b0;
        repeat (4) @(posedge i_clk);
        end_of_test;
    end
endmodule
`default_nettype wire
